/* File: src/plg_pkg.sv */
// Purpose: Shared constants and carriers for the port loopback, pin alarm and invert slice.
// Assumes: 16-bit register data, 8-bit in-port offset, one port instance per slice.
// Notes: Offsets are in-port byte offsets; the port prefix is decoded outside.
`default_nettype none
package plg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] OFS_TIMING = 8'h44;
    localparam logic [7:0] OFS_LOOP_ALARM = 8'h46;
    localparam logic [7:0] OFS_TX_INVERT = 8'h4A;
    localparam logic [7:0] OFS_RX_INVERT = 8'h4C;
    localparam logic [7:0] OFS_IRQ_SUMMARY = 8'h50;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h58;
    localparam logic [7:0] OFS_EVT_MASK = 8'h5A;
    localparam logic [15:0] RST_LOOP_ALARM = 16'h0000;
    localparam logic [15:0] RST_TX_INVERT = 16'h0000;
    localparam logic [15:0] RST_RX_INVERT = 16'h0000;
    localparam logic RST_TIMING = 1'b0;
    localparam logic [1:0] RST_EVT = 2'h0;
    localparam logic [15:0] MASK_LOOP_ALARM = 16'h07FF;
    localparam logic [15:0] MASK_TX_INVERT = 16'h17FF;
    localparam logic [15:0] MASK_RX_INVERT = 16'h16DE;
    localparam int POS_TIMING = 0;
    localparam int POS_LOOP_HI = 10;
    localparam int POS_LOOP_LO = 8;
    localparam int POS_PIN_B_HI = 7;
    localparam int POS_PIN_B_LO = 4;
    localparam int POS_PIN_A_HI = 3;
    localparam int POS_PIN_A_LO = 0;
    localparam int POS_PORT_SUM = 9;
    localparam int POS_LINE_SUM = 8;
    localparam int EVT_PORT_SUM = 0;
    localparam int EVT_LINE_SUM = 1;

    typedef struct packed {
        logic analog_loop;
        logic line_loop;
        logic payload_loop;
        logic diagnostic_loop;
    } plg_loop_t;

    typedef struct packed {
        logic loss_of_signal;
        logic out_of_frame;
        logic loss_of_frame;
        logic alarm_indication;
        logic remote_alarm;
        logic ds3_idle;
    } plg_alarms_t;

    // Bit order matches the transmit invert register, bit 12 down to bit 0
    typedef struct packed {
        logic frame_start_out;
        logic spare11;
        logic serial;
        logic overhead_sof;
        logic overhead_enable;
        logic overhead_data;
        logic overhead_clock;
        logic frame_start_in;
        logic negative;
        logic data;
        logic line_clock;
        logic clock_out;
        logic clock_in;
    } plg_tx_pins_t;

    // Bit order matches the receive invert register, bit 12 down to bit 0
    typedef struct packed {
        logic frame_start_out;
        logic spare11;
        logic serial;
        logic overhead_sof;
        logic spare8;
        logic overhead_data;
        logic overhead_clock;
        logic spare5;
        logic negative;
        logic positive;
        logic line_clock;
        logic clock_out;
        logic spare0;
    } plg_rx_pins_t;
endpackage : plg_pkg
`default_nettype wire

/* File: src/plg_loop_decode.sv */
// Purpose: Decode the three-bit loopback field into the four loopback enables.
// Assumes: Field comes straight from a register.
// Notes: Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module plg_loop_decode (
    input wire logic [2:0] loopback_select_field,
    output plg_pkg::plg_loop_t loop
);
    always_comb
    begin
        loop = '0;
        case (loopback_select_field)
            3'h0: loop = '0;
            3'h1: loop.analog_loop = 1'b1;
            3'h2: loop.line_loop = 1'b1;
            3'h3: loop.payload_loop = 1'b1;
            3'h6:
            begin
                loop.line_loop = 1'b1;
                loop.diagnostic_loop = 1'b1;
            end
            default: loop.diagnostic_loop = 1'b1;
        endcase
    end
endmodule : plg_loop_decode
`default_nettype wire

/* File: src/plg_alarm_select.sv */
// Purpose: Route one alarm status, or a fixed combination, to a general-purpose pin.
// Assumes: Alarm levels are synchronous to clk.
// Notes: The pin drives only while the global pin configuration enables it as output.
`timescale 1ns/100ps
`default_nettype none
module plg_alarm_select (
    input wire logic [3:0] alarm_select,
    input wire plg_pkg::plg_alarms_t alarms,
    input wire logic out_en,
    output logic pin_out,
    output logic pin_oe
);
    function automatic logic pick(input logic [3:0] code, input plg_pkg::plg_alarms_t a);
        logic r;
        r = 1'b0;
        case (code)
            4'h0: r = a.loss_of_signal;
            4'h1: r = a.out_of_frame;
            4'h2: r = a.loss_of_frame;
            4'h3: r = a.alarm_indication;
            4'h4: r = a.remote_alarm;
            4'h5: r = a.ds3_idle;
            4'hB, 4'hD: r = a.loss_of_signal | a.loss_of_frame | a.alarm_indication;
            4'hE: r = a.remote_alarm | a.ds3_idle;
            4'hF: r = |a;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick

    // Undriven pin is left to the outside pull; the output level is held low then
    assign pin_oe = out_en;
    assign pin_out = out_en & pick(alarm_select, alarms);
endmodule : plg_alarm_select
`default_nettype wire

/* File: src/plg_port_ctrl.sv */
// Purpose: Per-port loopback, pin alarm routing, pin inversion and interrupt summary slice.
// Assumes: Single 20 MHz clock; register port with read data one cycle after the strobe.
// Notes: Pin inversion is a plain XOR so that clocks pass without a register stage.
//
// Behaviour
// - Timing-select bit 0 uses output clocks, 1 uses input clocks for line data.
// - Loopback codes 000,001,010,011 give none, analog, line, payload loopback.
// - Codes 10X and 111 give diagnostic alone; 110 gives line plus diagnostic.
// - Bits 7..4 choose the B pin alarm, only when that pin is output-enabled.
// - Bits 3..0 choose the A pin alarm, only when that pin is output-enabled.
// - Codes 0000..0101 give signal loss, out-of-frame, frame loss, indication, remote, idle.
// - 1011/1101 combine loss, frame loss, indication; 1110 remote+idle; 1111 all six.
// - Each set transmit invert bit inverts its transmit pin.
// - Each set receive invert bit inverts its receive pin.
// - Port summary bit 9 follows enabled latched port status; drives interrupt if enabled.
// - Line-code summary bit 8 follows enabled latched coder status; drives interrupt if enabled.
`timescale 1ns/100ps
`default_nettype none
module plg_port_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic [15:0] port_status_latched,
    input wire logic [15:0] port_status_irq_en,
    input wire logic [15:0] line_code_latched,
    input wire logic [15:0] line_code_irq_en,
    input wire logic [4:0] other_summaries,
    input wire logic global_port_irq_enable,
    output logic port_irq,
    output logic evt_irq,
    output logic tx_line_timing_select,
    output plg_pkg::plg_loop_t loop,
    input wire plg_pkg::plg_alarms_t alarms,
    input wire logic pin_a_out_en,
    input wire logic pin_b_out_en,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe,
    input wire plg_pkg::plg_tx_pins_t tx_pins_in,
    output plg_pkg::plg_tx_pins_t tx_pins_out,
    input wire plg_pkg::plg_rx_pins_t rx_pins_in,
    output plg_pkg::plg_rx_pins_t rx_pins_out
);
    typedef struct packed {
        logic [15:0] loop_alarm;
        logic [15:0] tx_invert;
        logic [15:0] rx_invert;
        logic timing;
        logic [1:0] evt_status;
        logic [1:0] evt_mask;
        logic port_sum_q;
        logic line_sum_q;
        logic [15:0] rdata;
    } plg_state_t;

    plg_state_t st;
    plg_state_t next_st;
    logic port_status_summary;
    logic line_code_summary;
    logic [15:0] summary_word;
    logic [1:0] evt_set;

    // Summaries are never stored, so they clear as soon as the sources clear
    assign port_status_summary = |(port_status_latched & port_status_irq_en);
    assign line_code_summary = |(line_code_latched & line_code_irq_en);

    always_comb
    begin
        summary_word = '0;
        summary_word[plg_pkg::POS_PORT_SUM] = port_status_summary;
        summary_word[plg_pkg::POS_LINE_SUM] = line_code_summary;
        summary_word[7:4] = other_summaries[4:1];
        summary_word[0] = other_summaries[0];
    end

    always_comb
    begin
        next_st = st;
        next_st.port_sum_q = port_status_summary;
        next_st.line_sum_q = line_code_summary;
        evt_set = '0;
        evt_set[plg_pkg::EVT_PORT_SUM] = port_status_summary & ~st.port_sum_q;
        evt_set[plg_pkg::EVT_LINE_SUM] = line_code_summary & ~st.line_sum_q;
        next_st.rdata = '0;
        if (wr)
        begin
            case (addr)
                plg_pkg::OFS_TIMING: next_st.timing = wdata[plg_pkg::POS_TIMING];
                plg_pkg::OFS_LOOP_ALARM: next_st.loop_alarm = wdata & plg_pkg::MASK_LOOP_ALARM;
                plg_pkg::OFS_TX_INVERT: next_st.tx_invert = wdata & plg_pkg::MASK_TX_INVERT;
                plg_pkg::OFS_RX_INVERT: next_st.rx_invert = wdata & plg_pkg::MASK_RX_INVERT;
                plg_pkg::OFS_EVT_MASK: next_st.evt_mask = wdata[1:0];
                default: next_st.rdata = '0;
            endcase
        end
        if (rd)
        begin
            case (addr)
                plg_pkg::OFS_TIMING: next_st.rdata = {15'h0000, st.timing};
                plg_pkg::OFS_LOOP_ALARM: next_st.rdata = st.loop_alarm;
                plg_pkg::OFS_TX_INVERT: next_st.rdata = st.tx_invert;
                plg_pkg::OFS_RX_INVERT: next_st.rdata = st.rx_invert;
                plg_pkg::OFS_IRQ_SUMMARY: next_st.rdata = summary_word;
                plg_pkg::OFS_EVT_STATUS:
                begin
                    next_st.rdata = {14'h0000, st.evt_status};
                    next_st.evt_status = '0;
                end
                plg_pkg::OFS_EVT_MASK: next_st.rdata = {14'h0000, st.evt_mask};
                default: next_st.rdata = '0;
            endcase
        end
        // Set after the read clear so an event in the clearing cycle survives
        next_st.evt_status = next_st.evt_status | evt_set;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st.loop_alarm <= plg_pkg::RST_LOOP_ALARM;
            st.tx_invert <= plg_pkg::RST_TX_INVERT;
            st.rx_invert <= plg_pkg::RST_RX_INVERT;
            st.timing <= plg_pkg::RST_TIMING;
            st.evt_status <= plg_pkg::RST_EVT;
            st.evt_mask <= plg_pkg::RST_EVT;
            st.port_sum_q <= 1'b0;
            st.line_sum_q <= 1'b0;
            st.rdata <= 16'h0000;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign tx_line_timing_select = st.timing;
    // Other summary bits reach the pin too; the global enable gates the whole port
    assign port_irq = global_port_irq_enable & (|summary_word);
    assign evt_irq = |(st.evt_status & st.evt_mask);
    assign tx_pins_out = tx_pins_in ^ st.tx_invert[12:0];
    assign rx_pins_out = rx_pins_in ^ st.rx_invert[12:0];

    plg_loop_decode u_loop (
        .loopback_select_field(st.loop_alarm[plg_pkg::POS_LOOP_HI:plg_pkg::POS_LOOP_LO]),
        .loop(loop)
    );

    plg_alarm_select u_pin_a (
        .alarm_select(st.loop_alarm[plg_pkg::POS_PIN_A_HI:plg_pkg::POS_PIN_A_LO]),
        .alarms(alarms),
        .out_en(pin_a_out_en),
        .pin_out(pin_a_out),
        .pin_oe(pin_a_oe)
    );

    plg_alarm_select u_pin_b (
        .alarm_select(st.loop_alarm[plg_pkg::POS_PIN_B_HI:plg_pkg::POS_PIN_B_LO]),
        .alarms(alarms),
        .out_en(pin_b_out_en),
        .pin_out(pin_b_out),
        .pin_oe(pin_b_oe)
    );

    property p_timing_write;
        @(posedge clk) disable iff (!arst_n)
        (wr && addr == plg_pkg::OFS_TIMING) |=> tx_line_timing_select == $past(wdata[0]);
    endproperty
    a_timing_write: assert property (p_timing_write) else $error("timing select not loaded");

    property p_loop_low;
        @(posedge clk) disable iff (!arst_n)
        (st.loop_alarm[10] == 1'b0) |->
            loop == {st.loop_alarm[9:8] == 2'h1, st.loop_alarm[9:8] == 2'h2,
                     st.loop_alarm[9:8] == 2'h3, 1'b0};
    endproperty
    a_loop_low: assert property (p_loop_low) else $error("low loopback code wrong");

    property p_loop_high;
        @(posedge clk) disable iff (!arst_n)
        (st.loop_alarm[10] == 1'b1) |->
            loop.diagnostic_loop && !loop.analog_loop && !loop.payload_loop
            && loop.line_loop == (st.loop_alarm[9:8] == 2'h2);
    endproperty
    a_loop_high: assert property (p_loop_high) else $error("high loopback code wrong");

    property p_pin_b_gate;
        @(posedge clk) disable iff (!arst_n)
        !pin_b_out_en |-> !pin_b_out && !pin_b_oe;
    endproperty
    a_pin_b_gate: assert property (p_pin_b_gate) else $error("pin B driven while disabled");

    property p_pin_a_los;
        @(posedge clk) disable iff (!arst_n)
        (pin_a_out_en && st.loop_alarm[3:0] == 4'h0) |-> pin_a_out == alarms.loss_of_signal;
    endproperty
    a_pin_a_los: assert property (p_pin_a_los) else $error("pin A not signal loss");

    property p_pin_b_idle;
        @(posedge clk) disable iff (!arst_n)
        (pin_b_out_en && st.loop_alarm[7:4] == 4'h5) |-> pin_b_out == alarms.ds3_idle;
    endproperty
    a_pin_b_idle: assert property (p_pin_b_idle) else $error("pin B not idle");

    property p_pin_a_all;
        @(posedge clk) disable iff (!arst_n)
        (pin_a_out_en && st.loop_alarm[3:0] == 4'hF) |-> pin_a_out == (|alarms);
    endproperty
    a_pin_a_all: assert property (p_pin_a_all) else $error("pin A not all alarms");

    property p_tx_invert;
        @(posedge clk) disable iff (!arst_n)
        (wr && addr == plg_pkg::OFS_TX_INVERT) |=>
            (tx_pins_out ^ tx_pins_in) == ($past(wdata[12:0]) & 13'h17FF);
    endproperty
    a_tx_invert: assert property (p_tx_invert) else $error("tx inversion mismatch");

    property p_rx_invert;
        @(posedge clk) disable iff (!arst_n)
        (wr && addr == plg_pkg::OFS_RX_INVERT) |=>
            (rx_pins_out ^ rx_pins_in) == ($past(wdata[12:0]) & 13'h16DE);
    endproperty
    a_rx_invert: assert property (p_rx_invert) else $error("rx inversion mismatch");

    property p_port_sum_irq;
        @(posedge clk) disable iff (!arst_n)
        (|(port_status_latched & port_status_irq_en)) && global_port_irq_enable |-> port_irq;
    endproperty
    a_port_sum_irq: assert property (p_port_sum_irq) else $error("no port-summary irq");

    property p_line_sum_read;
        @(posedge clk) disable iff (!arst_n)
        (rd && addr == plg_pkg::OFS_IRQ_SUMMARY) |=>
            rdata[8] == $past(|(line_code_latched & line_code_irq_en));
    endproperty
    a_line_sum_read: assert property (p_line_sum_read) else $error("line sum misread");

    property p_unused_code;
        @(posedge clk) disable iff (!arst_n)
        (st.loop_alarm[3:0] inside {4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC}) |-> !pin_a_out;
    endproperty
    a_unused_code: assert property (p_unused_code) else $error("unused code drove pin");

    property p_evt_sticky;
        @(posedge clk) disable iff (!arst_n)
        $rose(port_status_summary) |=> st.evt_status[0];
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) else $error("event not latched");

    property p_port_sum_read;
        @(posedge clk) disable iff (!arst_n)
        (rd && addr == plg_pkg::OFS_IRQ_SUMMARY) |=>
            rdata[9] == $past(|(port_status_latched & port_status_irq_en));
    endproperty
    a_port_sum_read: assert property (p_port_sum_read) else $error("port sum misread");

    property p_irq_gate;
        @(posedge clk) disable iff (!arst_n)
        !global_port_irq_enable |-> !port_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

    property p_line_sum_irq;
        @(posedge clk) disable iff (!arst_n)
        (|(line_code_latched & line_code_irq_en)) && global_port_irq_enable |-> port_irq;
    endproperty
    a_line_sum_irq: assert property (p_line_sum_irq) else $error("no line-code irq");

    property p_evt_clear;
        @(posedge clk) disable iff (!arst_n)
        (rd && addr == plg_pkg::OFS_EVT_STATUS && evt_set == 2'h0) |=> st.evt_status == 2'h0;
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event status not cleared");

    property p_pin_a_gate;
        @(posedge clk) disable iff (!arst_n)
        !pin_a_out_en |-> !pin_a_out && !pin_a_oe;
    endproperty
    a_pin_a_gate: assert property (p_pin_a_gate) else $error("pin A driven off");

    property p_pin_b_combo;
        @(posedge clk) disable iff (!arst_n)
        (pin_b_out_en && st.loop_alarm[7:4] inside {4'hB, 4'hD}) |->
            pin_b_out == (alarms.loss_of_signal | alarms.loss_of_frame
                          | alarms.alarm_indication);
    endproperty
    a_pin_b_combo: assert property (p_pin_b_combo) else $error("pin B combo wrong");

    property p_rx_reserved;
        @(posedge clk) disable iff (!arst_n)
        (st.rx_invert & ~plg_pkg::MASK_RX_INVERT) == 16'h0000;
    endproperty
    a_rx_reserved: assert property (p_rx_reserved) else $error("rx reserved bit set");

    c_line_diag: cover property (@(posedge clk) disable iff (!arst_n)
        loop.line_loop && loop.diagnostic_loop);
    c_pin_combo: cover property (@(posedge clk) disable iff (!arst_n)
        pin_b_out_en && st.loop_alarm[7:4] == 4'hB && pin_b_out);
    c_port_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(port_irq));
    c_evt_clear: cover property (@(posedge clk) disable iff (!arst_n)
        rd && addr == plg_pkg::OFS_EVT_STATUS && st.evt_status != 2'h0);
endmodule : plg_port_ctrl
`default_nettype wire

/* File: tb/plg_host.sv */
// Purpose: Host processor model on the register port of the port control slice.
// Assumes: Read data stand in the cycle after the read strobe only.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module plg_host (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [15:0] rdata
);
    initial
    begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        // Only this cycle carries the answer
        d = rdata;
    endtask : rd_reg
endmodule : plg_host
`default_nettype wire

/* File: tb/test_port_loopback_gpio_invert_ctrl.sv */
// Purpose: Self-checking bench for the port loopback, pin alarm and invert slice.
// Assumes: Event status and mask at 0x58 and 0x5A as the designer placed them.
// Notes: Decode expectations come from small functions written here; read-back masks come from plg_pkg.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_port_loopback_gpio_invert_ctrl;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, psl, pse, lcl, lce, d, v, w, x;
    logic [15:0] exp_q [$];
    logic wr, rd, gen, port_irq, evt_irq, timing_sel, a_en, b_en, a_out, a_oe, b_out, b_oe;
    logic [4:0] oth;
    plg_pkg::plg_loop_t loop;
    plg_pkg::plg_alarms_t alarms;
    plg_pkg::plg_tx_pins_t tx_in, tx_out;
    plg_pkg::plg_rx_pins_t rx_in, rx_out;
    integer seed = 40240;
    integer err_count = 0;
    integer tests_run = 0;
    logic [7:0] ofs [4] = '{8'h44, 8'h46, 8'h4A, 8'h4C};

    always #25 clk = ~clk;

    plg_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    plg_port_ctrl uut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .port_status_latched(psl), .port_status_irq_en(pse),
        .line_code_latched(lcl), .line_code_irq_en(lce), .other_summaries(oth),
        .global_port_irq_enable(gen), .port_irq(port_irq), .evt_irq(evt_irq),
        .tx_line_timing_select(timing_sel), .loop(loop), .alarms(alarms), .pin_a_out_en(a_en),
        .pin_b_out_en(b_en), .pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_out(b_out),
        .pin_b_oe(b_oe), .tx_pins_in(tx_in), .tx_pins_out(tx_out), .rx_pins_in(rx_in),
        .rx_pins_out(rx_out));

    function automatic logic [3:0] loop_exp(input logic [2:0] c);
        case (c)
            3'h0: return 4'h0;
            3'h1: return 4'h8;
            3'h2: return 4'h4;
            3'h3: return 4'h2;
            3'h6: return 4'h5;
            default: return 4'h1;
        endcase
    endfunction : loop_exp

    // Alarm bits 5..0: signal loss, out of frame, frame loss, alarm indication, remote, idle
    function automatic logic alarm_exp(input logic [3:0] s, input logic [5:0] a);
        if (s <= 4'h5)
            return a[3'h5 - s[2:0]];
        case (s)
            4'hB, 4'hD: return a[5] | a[3] | a[2];
            4'hE: return a[1] | a[0];
            4'hF: return |a;
            default: return 1'b0;
        endcase
    endfunction : alarm_exp

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end

    initial
    begin
        {psl, pse, lcl, lce, oth, gen, a_en, b_en} = '0;
        alarms = '0;
        tx_in = '0;
        rx_in = '0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            host.rd_reg(ofs[i], d);
            `CHK(d, 16'h0000)
        end
        `CHK(4'(loop), 4'h0)
        `CHK(timing_sel, 1'b0)
        host.wr_reg(plg_pkg::OFS_TIMING, 16'hFFFF);
        `CHK(timing_sel, 1'b1)
        host.rd_reg(plg_pkg::OFS_TIMING, d);
        `CHK(d, 16'h0001)
        host.wr_reg(plg_pkg::OFS_TIMING, 16'hFFFE);
        `CHK(timing_sel, 1'b0)
        // Reserved bits are set at random to prove they do not disturb decoding
        for (int c = 0; c < 8; c++)
        begin
            v = 16'($random(seed));
            v[10:8] = 3'(c);
            host.wr_reg(plg_pkg::OFS_LOOP_ALARM, v);
            `CHK(4'(loop), loop_exp(3'(c)))
            host.rd_reg(plg_pkg::OFS_LOOP_ALARM, d);
            `CHK(d, v & plg_pkg::MASK_LOOP_ALARM)
        end
        for (int s = 0; s < 16; s++)
        begin
            host.wr_reg(plg_pkg::OFS_LOOP_ALARM, {8'h00, ~4'(s), 4'(s)});
            repeat (5)
            begin
                @(posedge clk);
                alarms <= 6'($random(seed));
                a_en <= 1'($random(seed));
                b_en <= 1'($random(seed));
                #1;
                `CHK(a_out, a_en & alarm_exp(4'(s), 6'(alarms)))
                `CHK(b_out, b_en & alarm_exp(~4'(s), 6'(alarms)))
                `CHK({a_oe, b_oe}, {a_en, b_en})
            end
        end
        repeat (6)
        begin
            v = 16'($random(seed));
            w = 16'($random(seed));
            host.wr_reg(plg_pkg::OFS_TX_INVERT, v);
            host.wr_reg(plg_pkg::OFS_RX_INVERT, w);
            // Model queue holds the expected read-back words in bus order
            exp_q.push_back(v & plg_pkg::MASK_TX_INVERT);
            exp_q.push_back(w & plg_pkg::MASK_RX_INVERT);
            host.rd_reg(plg_pkg::OFS_TX_INVERT, d);
            x = exp_q.pop_front();
            `CHK(d, x)
            host.rd_reg(plg_pkg::OFS_RX_INVERT, d);
            x = exp_q.pop_front();
            `CHK(d, x)
            @(posedge clk);
            tx_in <= 13'($random(seed));
            rx_in <= 13'($random(seed));
            #1;
            `CHK(13'(tx_out), 13'(tx_in) ^ (v[12:0] & 13'h17FF))
            `CHK(13'(rx_out), 13'(rx_in) ^ (w[12:0] & 13'h16DE))
        end
        host.wr_reg(plg_pkg::OFS_IRQ_SUMMARY, 16'hFFFF);
        repeat (10)
        begin
            @(posedge clk);
            psl <= 16'($random(seed)) & 16'($random(seed));
            pse <= 16'($random(seed)) & 16'($random(seed));
            lcl <= 16'($random(seed)) & 16'($random(seed));
            lce <= 16'($random(seed)) & 16'($random(seed));
            oth <= 5'($random(seed)) & 5'($random(seed));
            gen <= 1'($random(seed));
            #1;
            v = {6'h00, |(psl & pse), |(lcl & lce), oth[4:1], 3'h0, oth[0]};
            `CHK(port_irq, gen & (|v))
            host.rd_reg(plg_pkg::OFS_IRQ_SUMMARY, d);
            `CHK(d, v)
        end
        host.rd_reg(8'h10, d);
        `CHK(d, 16'h0000)
        // Event block: clear leftovers, then raise one summary with the mask open
        @(posedge clk);
        {psl, pse, lcl, lce, oth} <= '0;
        repeat (3) @(posedge clk);
        host.rd_reg(plg_pkg::OFS_EVT_STATUS, d);
        host.wr_reg(plg_pkg::OFS_EVT_MASK, 16'h0003);
        host.rd_reg(plg_pkg::OFS_EVT_MASK, d);
        `CHK(d, 16'h0003)
        @(posedge clk);
        psl <= 16'h0004;
        pse <= 16'h0004;
        repeat (3) @(posedge clk);
        #1;
        `CHK(evt_irq, 1'b1)
        host.rd_reg(plg_pkg::OFS_EVT_STATUS, d);
        `CHK(d, 16'h0001)
        @(posedge clk);
        #1;
        `CHK(evt_irq, 1'b0)
        host.wr_reg(plg_pkg::OFS_EVT_MASK, 16'h0000);
        @(posedge clk);
        lcl <= 16'h0100;
        lce <= 16'h0100;
        repeat (3) @(posedge clk);
        #1;
        `CHK(evt_irq, 1'b0)
        host.rd_reg(plg_pkg::OFS_EVT_STATUS, d);
        `CHK(d, 16'h0002)
        close_out();
    end
endmodule : test_port_loopback_gpio_invert_ctrl
`undef CHK
`default_nettype wire
